// [design/flash_host_pkg.sv]
// Package holding the flash host controller constants, types and register map.
package flash_host_pkg;
   // Bus widths of the flash device
   localparam int ADDR_W = 21;
   localparam int DATA_W = 8;
   // Command cycle addresses, only the low eleven bits matter
   localparam logic [10:0] UNLOCK_ADDR_1 = 11'h555;
   localparam logic [10:0] UNLOCK_ADDR_2 = 11'h2AA;
   // Command data codes
   localparam logic [7:0] CODE_UNLOCK_1 = 8'hAA;
   localparam logic [7:0] CODE_UNLOCK_2 = 8'h55;
   localparam logic [7:0] CODE_RESET = 8'hF0;
   localparam logic [7:0] CODE_AUTOSEL = 8'h90;
   localparam logic [7:0] CODE_PROGRAM = 8'hA0;
   localparam logic [7:0] CODE_BYPASS = 8'h20;
   localparam logic [7:0] CODE_BYPASS_EXIT = 8'h00;
   localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CODE_BLOCK_ERASE = 8'h30;
   localparam logic [7:0] CODE_SUSPEND = 8'hB0;
   localparam logic [7:0] CODE_RESUME = 8'h30;
   // Status bit positions on the data lines
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int ERROR_BIT = 5;
   localparam int ETIMER_BIT = 3;
   // Bus cycle timing: cycles of 100 ns for each phase of a pin cycle
   localparam int CLK_NS = 100;
   localparam int PHASE_NS = 100;
   localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   // Software register offsets (word index)
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_DATA = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_RDATA = 4'h4;
   // Operation codes written to the command register
   typedef enum logic [3:0] {
      OP_NONE = 4'h0, OP_RESET = 4'h1, OP_AUTOSEL = 4'h2, OP_PROGRAM = 4'h3,
      OP_BYPASS = 4'h4, OP_BYP_PROG = 4'h5, OP_BYP_EXIT = 4'h6,
      OP_CHIP_ERASE = 4'h7, OP_BLK_ERASE = 4'h8, OP_BLK_ADD = 4'h9,
      OP_SUSPEND = 4'hA, OP_RESUME = 4'hB, OP_READ = 4'hC, OP_RESET3 = 4'hD
   } op_e;
   // Pin bundle driven toward the flash
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
   } flash_pins_s;
endpackage : flash_host_pkg

// [design/flash_host_ctrl.sv]
// Host controller that issues command sequences to a parallel flash device.
`timescale 1ns/1ps
module flash_host_ctrl #(
   parameter int SEQ_MAX = 6 // Longest command sequence in writes
) (
   input wire logic core_clk_i, // 10 MHz clock
   input wire logic rst_n_i, // Asynchronous reset, active low
   input wire logic [3:0] reg_addr_i, // Register index
   input wire logic [31:0] reg_wdata_i, // Register write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output logic [31:0] reg_rdata_o, // Read data, one cycle later
   output logic flash_ce_n_o, // Chip enable, active low
   output logic flash_oe_n_o, // Output enable, active low
   output logic flash_we_n_o, // Write enable, active low
   output logic [flash_host_pkg::ADDR_W-1:0] flash_addr_o, // Address pins
   output logic [flash_host_pkg::DATA_W-1:0] flash_dq_o, // Data pins driven
   output logic flash_dq_oe_o, // High while the host drives data
   input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_i // Data pins sampled
);
   // Bus cycle sequencer states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001, ST_SETUP = 5'b00010, ST_STROBE = 5'b00100,
      ST_HOLD = 5'b01000, ST_NEXT = 5'b10000
   } bus_state_e;

   // Strobe phase reload; the counter runs down to zero inside ST_STROBE
   localparam logic [$clog2(flash_host_pkg::PHASE_CYC+1)-1:0] PHASE_LOAD =
      ($clog2(flash_host_pkg::PHASE_CYC+1))'(flash_host_pkg::PHASE_CYC - 1);

   bus_state_e state_ff; // Sequencer state
   bus_state_e nxt_state; // Next sequencer state
   logic [flash_host_pkg::ADDR_W-1:0] tgt_addr_ff; // Target address register
   logic [flash_host_pkg::DATA_W-1:0] tgt_data_ff; // Target value register
   logic [3:0] op_ff; // Operation being run
   logic [2:0] step_ff; // Write index inside the sequence
   logic [2:0] len_ff; // Number of cycles in the sequence
   logic is_read_ff; // Current cycle is a bus read
   logic [7:0] rdata_ff; // Last data read from the device
   logic prev_toggle_ff; // Toggle bit of the previous status read
   logic toggled_ff; // Toggle bit changed between two reads
   logic poll_done_ff; // Operation seen finished by polling
   logic err_ff; // Error bit seen while polling
   logic bypass_ff; // Device believed to be in bypass mode
   logic suspended_ff; // Device believed to hold a suspended erase
   logic busy_ff; // Controller running a sequence
   logic [$clog2(flash_host_pkg::PHASE_CYC+1)-1:0] phase_ff; // Phase counter
   flash_host_pkg::flash_pins_s pins_ff; // Registered pin bundle
   logic [31:0] rdata_bus_ff; // Register read data
   logic [10:0] cyc_addr; // Low address for the current write
   logic [7:0] cyc_data; // Data for the current write
   logic cyc_tgt; // Current write uses the target address
   logic [2:0] nxt_len; // Length for a newly accepted operation
   logic accept; // A new operation is accepted

   // Sequence length per operation
   always_comb begin
      unique case (reg_wdata_i[3:0])
         flash_host_pkg::OP_RESET, flash_host_pkg::OP_SUSPEND,
         flash_host_pkg::OP_RESUME, flash_host_pkg::OP_BLK_ADD,
         flash_host_pkg::OP_READ: nxt_len = 3'd1;
         flash_host_pkg::OP_BYP_PROG, flash_host_pkg::OP_BYP_EXIT: nxt_len = 3'd2;
         flash_host_pkg::OP_AUTOSEL, flash_host_pkg::OP_BYPASS,
         flash_host_pkg::OP_RESET3: nxt_len = 3'd3;
         flash_host_pkg::OP_PROGRAM: nxt_len = 3'd4;
         flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_BLK_ERASE: nxt_len = 3'd6;
         default: nxt_len = 3'd0;
      endcase
   end

   assign accept = reg_wr_i && (reg_addr_i == flash_host_pkg::REG_CMD) && !busy_ff &&
      (nxt_len != 3'd0);

   // Address and data of each write in a sequence
   always_comb begin
      cyc_addr = flash_host_pkg::UNLOCK_ADDR_1;
      cyc_data = flash_host_pkg::CODE_UNLOCK_1;
      cyc_tgt = 1'b0;
      unique case (op_ff)
         flash_host_pkg::OP_RESET: cyc_data = flash_host_pkg::CODE_RESET;
         flash_host_pkg::OP_SUSPEND: cyc_data = flash_host_pkg::CODE_SUSPEND;
         flash_host_pkg::OP_RESUME: cyc_data = flash_host_pkg::CODE_RESUME;
         flash_host_pkg::OP_BLK_ADD: begin
            cyc_data = flash_host_pkg::CODE_BLOCK_ERASE;
            cyc_tgt = 1'b1;
         end
         flash_host_pkg::OP_BYP_PROG: begin
            cyc_data = (step_ff == 3'd0) ? flash_host_pkg::CODE_PROGRAM : tgt_data_ff;
            cyc_tgt = (step_ff != 3'd0);
         end
         flash_host_pkg::OP_BYP_EXIT: begin
            cyc_data = (step_ff == 3'd0) ? flash_host_pkg::CODE_AUTOSEL :
               flash_host_pkg::CODE_BYPASS_EXIT;
         end
         default: begin
            // Unlock pair, then the command code at the first unlock address
            if (step_ff == 3'd1 || step_ff == 3'd4) begin
               cyc_addr = flash_host_pkg::UNLOCK_ADDR_2;
               cyc_data = flash_host_pkg::CODE_UNLOCK_2;
            end else if (step_ff == 3'd2) begin
               unique case (op_ff)
                  flash_host_pkg::OP_AUTOSEL: cyc_data = flash_host_pkg::CODE_AUTOSEL;
                  flash_host_pkg::OP_PROGRAM: cyc_data = flash_host_pkg::CODE_PROGRAM;
                  flash_host_pkg::OP_BYPASS: cyc_data = flash_host_pkg::CODE_BYPASS;
                  flash_host_pkg::OP_RESET3: cyc_data = flash_host_pkg::CODE_RESET;
                  default: cyc_data = flash_host_pkg::CODE_ERASE_SETUP;
               endcase
            end else if (step_ff == 3'd3 && op_ff == flash_host_pkg::OP_PROGRAM) begin
               cyc_data = tgt_data_ff;
               cyc_tgt = 1'b1;
            end else if (step_ff == 3'd5) begin
               cyc_data = (op_ff == flash_host_pkg::OP_CHIP_ERASE) ?
                  flash_host_pkg::CODE_CHIP_ERASE : flash_host_pkg::CODE_BLOCK_ERASE;
               cyc_tgt = (op_ff == flash_host_pkg::OP_BLK_ERASE);
            end
         end
      endcase
   end

   // Sequencer next state
   // Writes of one sequence follow each other with no idle gap, so the
   // device decoder sees them as one command
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: if (accept) nxt_state = ST_SETUP;
         ST_SETUP: nxt_state = ST_STROBE;
         ST_STROBE: if (phase_ff == '0) nxt_state = ST_HOLD;
         ST_HOLD: nxt_state = ST_NEXT;
         ST_NEXT: nxt_state = (step_ff + 3'd1 >= len_ff) ? ST_IDLE : ST_SETUP;
      endcase
   end

   // State register
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) state_ff <= ST_IDLE;
      else state_ff <= nxt_state;
   end

   // Operation capture and step counting
   // busy_ff drops with the last ST_NEXT edge, so a command written in that
   // same cycle still sees busy and is refused
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         op_ff <= 4'h0;
         step_ff <= 3'd0;
         len_ff <= 3'd0;
         is_read_ff <= 1'b0;
         busy_ff <= 1'b0;
         phase_ff <= '0;
      end else begin
         if (accept) begin
            op_ff <= reg_wdata_i[3:0];
            len_ff <= nxt_len;
            step_ff <= 3'd0;
            is_read_ff <= (reg_wdata_i[3:0] == flash_host_pkg::OP_READ);
            busy_ff <= 1'b1;
         end else if (state_ff == ST_NEXT) begin
            step_ff <= step_ff + 3'd1;
            if (step_ff + 3'd1 >= len_ff) busy_ff <= 1'b0;
         end
         if (state_ff == ST_SETUP) phase_ff <= PHASE_LOAD;
         else if (state_ff == ST_STROBE && phase_ff != '0) phase_ff <= phase_ff - 1'b1;
      end
   end

   // Target address and value registers
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tgt_addr_ff <= '0;
         tgt_data_ff <= '0;
      end else if (reg_wr_i && !busy_ff) begin
         if (reg_addr_i == flash_host_pkg::REG_ADDR)
            tgt_addr_ff <= reg_wdata_i[flash_host_pkg::ADDR_W-1:0];
         if (reg_addr_i == flash_host_pkg::REG_DATA) tgt_data_ff <= reg_wdata_i[7:0];
      end
   end

   // Pin drive: address and data set up, then a strobe phase, then release
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
      end else begin
         unique case (state_ff)
            ST_SETUP: begin
               pins_ff.ce_n <= 1'b0;
               pins_ff.addr <= (cyc_tgt || is_read_ff) ? tgt_addr_ff :
                  {{(flash_host_pkg::ADDR_W-11){1'b0}}, cyc_addr};
               pins_ff.dq_out <= cyc_data;
               pins_ff.dq_oe <= !is_read_ff;
            end
            ST_STROBE: begin
               // Strobe goes low one cycle after entry and stays low through ST_HOLD;
               // the device latches write data as it rises again on entry to ST_NEXT
               pins_ff.we_n <= is_read_ff;
               pins_ff.oe_n <= !is_read_ff;
            end
            ST_HOLD: begin
               pins_ff.we_n <= 1'b1;
               pins_ff.oe_n <= 1'b1;
            end
            ST_NEXT: begin
               pins_ff.ce_n <= 1'b1;
               pins_ff.dq_oe <= 1'b0;
            end
            default: begin
               pins_ff.ce_n <= 1'b1;
               pins_ff.dq_oe <= 1'b0;
            end
         endcase
      end
   end

   // Status polling of read data
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= 8'h00;
         prev_toggle_ff <= 1'b0;
         toggled_ff <= 1'b0;
         poll_done_ff <= 1'b0;
         err_ff <= 1'b0;
      end else if (is_read_ff && state_ff == ST_HOLD) begin
         // Output enable has been low for a full cycle here, so the lines
         // carry the device's answer and not the released level
         rdata_ff <= flash_dq_i;
         prev_toggle_ff <= flash_dq_i[flash_host_pkg::TOGGLE_BIT];
         toggled_ff <= flash_dq_i[flash_host_pkg::TOGGLE_BIT] ^ prev_toggle_ff;
         poll_done_ff <= !(flash_dq_i[flash_host_pkg::TOGGLE_BIT] ^ prev_toggle_ff);
         err_ff <= flash_dq_i[flash_host_pkg::ERROR_BIT];
      end
   end

   // Mode tracking for bypass and suspend
   // A read/reset leaves bypass set, as the device stays in bypass mode too
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bypass_ff <= 1'b0;
         suspended_ff <= 1'b0;
      end else if (accept) begin
         unique case (reg_wdata_i[3:0])
            flash_host_pkg::OP_BYPASS: bypass_ff <= 1'b1;
            flash_host_pkg::OP_BYP_EXIT: bypass_ff <= 1'b0;
            flash_host_pkg::OP_SUSPEND: suspended_ff <= 1'b1;
            flash_host_pkg::OP_RESUME: suspended_ff <= 1'b0;
            default: ;
         endcase
      end
   end

   // Register read port
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) rdata_bus_ff <= 32'h0000_0000;
      else if (reg_rd_i) begin
         unique case (reg_addr_i)
            flash_host_pkg::REG_CMD: rdata_bus_ff <= {28'h0, op_ff};
            flash_host_pkg::REG_ADDR: rdata_bus_ff <=
               {{(32-flash_host_pkg::ADDR_W){1'b0}}, tgt_addr_ff};
            flash_host_pkg::REG_DATA: rdata_bus_ff <= {24'h0, tgt_data_ff};
            flash_host_pkg::REG_STATUS: rdata_bus_ff <= {26'h0, suspended_ff, bypass_ff,
               err_ff, toggled_ff, poll_done_ff, busy_ff};
            flash_host_pkg::REG_RDATA: rdata_bus_ff <= {24'h0, rdata_ff};
            default: rdata_bus_ff <= 32'h0000_0000;
         endcase
      end else rdata_bus_ff <= 32'h0000_0000;
   end

   assign reg_rdata_o = rdata_bus_ff;
   assign flash_ce_n_o = pins_ff.ce_n;
   assign flash_oe_n_o = pins_ff.oe_n;
   assign flash_we_n_o = pins_ff.we_n;
   assign flash_addr_o = pins_ff.addr;
   assign flash_dq_o = pins_ff.dq_out;
   assign flash_dq_oe_o = pins_ff.dq_oe;
endmodule : flash_host_ctrl

// [test/flash_host_ctrl_asserts.sv]
// Checker of the flash host controller pin and register port timing.
`timescale 1ns/1ps
module flash_host_ctrl_asserts #(
   parameter int SEQ_MAX = 6 // Longest command sequence in writes
) (
   input wire logic core_clk_i, // Clock
   input wire logic rst_n_i, // Reset, active low
   input wire logic [3:0] reg_addr_i, // Register index
   input wire logic [31:0] reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   input wire logic [31:0] reg_rdata_o, // Read data
   input wire logic flash_ce_n_o, // Chip enable, active low
   input wire logic flash_oe_n_o, // Output enable, active low
   input wire logic flash_we_n_o, // Write enable, active low
   input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr_o, // Address pins
   input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_o, // Data driven
   input wire logic flash_dq_oe_o, // Data drive enable
   input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_i // Data sampled
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Register answers only in the cycle after a read strobe
   AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data outside the answer cycle");
   AST_UNMAPPED_ZERO: assert property (reg_rd_i && reg_addr_i > flash_host_pkg::REG_RDATA |=>
      reg_rdata_o == 32'h0) else $error("unmapped read not zero");
   // Bus reads and writes never collide on the data lines
   AST_READ_UNDRIVEN: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_dq_oe_o)
      else $error("host drives data during a read");
   AST_WRITE_SELECTED: assert property (!flash_we_n_o |->
      !flash_ce_n_o && flash_dq_oe_o && !$past(flash_ce_n_o)) else $error("write not framed");
   // Strobes last one cycle, then hold, then deselect
   AST_WE_PULSE: assert property ($fell(flash_we_n_o) |=>
      flash_we_n_o && !flash_ce_n_o ##1 flash_ce_n_o) else $error("write strobe shape wrong");
   AST_OE_PULSE: assert property ($fell(flash_oe_n_o) |=> flash_oe_n_o ##1 flash_ce_n_o)
      else $error("read strobe shape wrong");
   AST_PINS_HELD: assert property (!flash_we_n_o |->
      $stable(flash_addr_o) && $stable(flash_dq_o)) else $error("address or data moved");
   AST_ONE_STROBE: assert property ($fell(flash_ce_n_o) |-> ##1 flash_we_n_o != flash_oe_n_o)
      else $error("bus cycle without a single strobe");
endmodule : flash_host_ctrl_asserts
bind flash_host_ctrl flash_host_ctrl_asserts #(.SEQ_MAX(SEQ_MAX)) i_flash_host_ctrl_asserts (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o),
   .flash_we_n_o(flash_we_n_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
   .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i)
);

// [test/flash_dev_model.sv]
// Behavioural model of the parallel flash device driven by the host controller.
`timescale 1ns/1ps
module flash_dev_model #(
   parameter logic [7:0] MAKER_ID = 8'h5C, // Arbitrary identity value
   parameter logic [7:0] PART_ID = 8'h3E // Arbitrary identity value
) (
   input wire logic ce_n_i, // Chip enable, active low
   input wire logic oe_n_i, // Output enable, active low
   input wire logic we_n_i, // Write enable, active low
   input wire logic [20:0] addr_i, // Address pins
   input wire logic [7:0] dq_i, // Data from host
   output logic [7:0] dq_o // Data to host
);
   logic [7:0] mem [256]; // Small array on address bits 7:0
   logic [7:0] out = 8'h00; // Last byte put out
   logic [7:0] pd = 8'h00; // Value being programmed
   logic [15:0] blk = '0; // Blocks chosen for erase
   logic [15:0] prot = 16'h8000; // Protected blocks, skipped by erase
   logic tog = 1'b0; // Toggle status bit state
   logic byp = 1'b0; // Bypass mode
   logic ident = 1'b0; // Identification mode
   logic [10:0] a; // Command address
   int s, seq = 0, left = 0, back = 0; // Decoder step, program reads left, mode to return to
   int mode = 0; // 0 read, 2 program, 3 window, 4 erasing, 5 suspended, 6 chip erase
   initial for (int i = 0; i < 256; i++) mem[i] = i[7:0];
   assign a = addr_i[10:0];
   // Released lines show the inverse of the last value
   assign dq_o = (!ce_n_i && !oe_n_i) ? out : ~out;
   // Command decoder, data latched as write enable rises
   always @(posedge we_n_i) if (!ce_n_i) begin
      s = seq;
      seq = 0;
      if (mode == 2 || mode == 6) s = 0;
      else if ((mode == 3 || mode == 4) && dq_i == 8'hB0) mode = 5;
      else if (mode == 3 || mode == 4) mode = (dq_i == 8'hF0) ? 0 : mode;
      else if (mode == 5 && s == 0 && dq_i == 8'h30) mode = 4;
      else if ((s == 0 || s == 2) && dq_i == 8'hF0) ident = 1'b0;
      else if (byp && s == 0) seq = (dq_i == 8'hA0) ? 3 : (dq_i == 8'h90) ? 8 : 0;
      else if (s == 8) byp = dq_i != 8'h00;
      else if (s == 3) begin
         pd = dq_i;
         mem[addr_i[7:0]] = mem[addr_i[7:0]] & dq_i;
         back = mode;
         left = 2;
         mode = 2;
      end
      else if (s == 0 && a == 11'h555 && dq_i == 8'hAA) seq = 1;
      else if (s == 1 && a == 11'h2AA && dq_i == 8'h55) seq = 2;
      else if (s == 2 && a == 11'h555 && dq_i == 8'h90) ident = 1'b1;
      else if (s == 2 && a == 11'h555 && dq_i == 8'hA0) seq = 3;
      else if (s == 2 && a == 11'h555 && dq_i == 8'h20) byp = 1'b1;
      else if (s == 2 && a == 11'h555 && dq_i == 8'h80) seq = 4;
      else if (s == 4 && a == 11'h555 && dq_i == 8'hAA) seq = 5;
      else if (s == 5 && a == 11'h2AA && dq_i == 8'h55) seq = 6;
      else if (s == 6 && a == 11'h555 && dq_i == 8'h10) mode = 6;
      else if (s == 6 && dq_i == 8'h30) mode = 3;
      else ident = 1'b0;
      if (mode == 3 && dq_i == 8'h30) blk[addr_i[7:4]] = 1'b1;
   end
   // Bus read: array, identity or status; erase steps advance per status read
   always @(negedge oe_n_i) if (!ce_n_i) begin
      if (mode == 2) out = {~pd[7], tog, 6'h00};
      else if (mode == 3 || mode == 4 || mode == 6) out = {1'b0, tog, 2'h0, mode != 3, 3'h0};
      else if (mode == 5 && blk[addr_i[7:4]]) out = 8'h80;
      else if (ident) out = addr_i[0] ? PART_ID : MAKER_ID;
      else out = mem[addr_i[7:0]];
      if (mode == 2 || mode == 3 || mode == 4 || mode == 6) tog = ~tog;
      if (mode == 2 && --left == 0) mode = back;
      if (mode == 4 || mode == 6) begin
         for (int i = 0; i < 256; i++)
            if ((mode == 6 || blk[i / 16]) && !prot[i / 16]) mem[i] = 8'hFF;
         blk = '0;
         mode = 0;
      end
      if (mode == 3) mode = 4;
   end
endmodule : flash_dev_model

// [test/flash_host_ctrl_test.sv]
// Self-checking bench of the flash host controller against the flash model.
`timescale 1ns/1ps
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module flash_host_ctrl_test;
   localparam logic [7:0] MK = 8'h5C; // Arbitrary identity value
   localparam logic [7:0] PT = 8'h3E; // Arbitrary identity value
   typedef struct packed {
      logic [3:0] op; // Operation code
      logic [20:0] a; // Target address
      logic [7:0] d; // Value to program
      logic [7:0] e; // Byte a read should return
   } row_s;
   logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0; // Clock, reset, strobes
   logic [3:0] reg_addr = 4'h0; // Register index
   logic [31:0] reg_wdata = 32'h0, reg_rdata, v; // Register data
   logic ce_n, oe_n, we_n, dq_oe; // Flash strobes
   logic [20:0] addr; // Flash address
   logic [7:0] dq_o, dq_i; // Flash data both ways
   int mismatches = 0, checks_done = 0; // Tallies
   // Ops: 1 reset 2 ident 3 prog 4 bypass 5 bypass prog 6 exit 7 chip 8 block 9 add A susp B res C read
   row_s rows [33] = '{
      '{4'h1, 21'h0, 8'h0, 8'h0}, '{4'hC, 21'h12, 8'h0, 8'h12}, '{4'h3, 21'h37, 8'h25, 8'h0},
      '{4'hC, 21'h37, 8'h0, 8'h80}, '{4'hC, 21'h37, 8'h0, 8'hC0}, '{4'hC, 21'h37, 8'h0, 8'h25},
      '{4'h2, 21'h0, 8'h0, 8'h0}, '{4'hC, 21'h0, 8'h0, MK}, '{4'hC, 21'h1, 8'h0, PT},
      '{4'h1, 21'h0, 8'h0, 8'h0}, '{4'hC, 21'h1, 8'h0, 8'h01}, '{4'h4, 21'h0, 8'h0, 8'h0},
      '{4'h5, 21'h40, 8'h44, 8'h0}, '{4'hC, 21'h40, 8'h0, 8'h80}, '{4'hC, 21'h40, 8'h0, 8'hC0},
      '{4'hC, 21'h40, 8'h0, 8'h40}, '{4'h6, 21'h0, 8'h0, 8'h0}, '{4'h5, 21'h40, 8'h00, 8'h0},
      '{4'hC, 21'h40, 8'h0, 8'h40}, '{4'h8, 21'h20, 8'h0, 8'h0}, '{4'h9, 21'h30, 8'h0, 8'h0},
      '{4'hA, 21'h0, 8'h0, 8'h0}, '{4'hC, 21'h10, 8'h0, 8'h10}, '{4'hC, 21'h31, 8'h0, 8'h80},
      '{4'hC, 21'h25, 8'h0, 8'h80}, '{4'hB, 21'h0, 8'h0, 8'h0}, '{4'hC, 21'h31, 8'h0, 8'h08},
      '{4'hC, 21'h31, 8'h0, 8'hFF}, '{4'hC, 21'h25, 8'h0, 8'hFF}, '{4'hC, 21'h10, 8'h0, 8'h10},
      '{4'h7, 21'h0, 8'h0, 8'h0}, '{4'hC, 21'h10, 8'h0, 8'h48}, '{4'hC, 21'h10, 8'h0, 8'hFF}
   };
   flash_host_ctrl i_flash_host_ctrl (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_addr_o(addr),
      .flash_dq_o(dq_o), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_i));
   flash_dev_model #(.MAKER_ID(MK), .PART_ID(PT)) i_flash_dev_model (.ce_n_i(ce_n),
      .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(addr), .dq_i(dq_o), .dq_o(dq_i));
   // One register write cycle
   task automatic wr(input logic [3:0] ra, input logic [31:0] wd);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= ra;
      reg_wdata <= wd;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // One register read, data taken in the answer cycle
   task automatic rd(input logic [3:0] ra, output logic [31:0] rv);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= ra;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask : rd
   // Issue one operation, wait for idle, check the byte a read returns
   task automatic run(input row_s r);
      wr(flash_host_pkg::REG_ADDR, {11'h0, r.a});
      wr(flash_host_pkg::REG_DATA, {24'h0, r.d});
      wr(flash_host_pkg::REG_CMD, {28'h0, r.op});
      for (int i = 0; i < 100; i++) begin
         rd(flash_host_pkg::REG_STATUS, v);
         if (v[0] === 1'b0) break;
      end
      `CHECK(v[0], 1'b0)
      if (r.op == flash_host_pkg::OP_READ) begin
         rd(flash_host_pkg::REG_RDATA, v);
         `CHECK(v[7:0], r.e)
      end
   endtask : run
   // Print the tallies and the verdict, then stop
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   // Free-running 10 MHz clock
   initial forever #50 clk = ~clk;
   // Hang guard well beyond the expected run
   initial begin
      #3000000;
      mismatches++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      `CHECK({ce_n, oe_n, we_n, dq_oe}, 4'hE)
      foreach (rows[i]) run(rows[i]);
      rd(4'hF, v);
      `CHECK(v, 32'h0)
      wr(flash_host_pkg::REG_ADDR, 32'h12);
      wr(flash_host_pkg::REG_CMD, {28'h0, flash_host_pkg::OP_READ});
      rd(flash_host_pkg::REG_STATUS, v);
      `CHECK(v[0], 1'b1)
      wr(flash_host_pkg::REG_CMD, {28'h0, flash_host_pkg::OP_RESET});
      run('{4'h0, 21'h0, 8'h0, 8'h0});
      rd(flash_host_pkg::REG_RDATA, v);
      // Chip erase left every byte outside protected block 15 at FF; the refused reset must not replace the read op
      `CHECK(v[7:0], 8'hFF)
      rd(flash_host_pkg::REG_CMD, v);
      `CHECK(v[3:0], flash_host_pkg::OP_READ)
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      `CHECK({ce_n, dq_oe}, 2'h2)
      rst_n <= 1'b1;
      run('{4'hC, 21'h10, 8'h0, 8'hFF});
      tally_and_finish();
   end
endmodule : flash_host_ctrl_test
